// File: hw/rfap_pkg.sv
// shared constants for the rf input / attenuation panel controller
package rfap_pkg;
  // ******************************************
  // clock and times
  // ******************************************
  localparam int CLK_HZ   = 10_000_000;
  localparam int HOLD_MS  = 500;   // hold time before auto-repeat
  localparam int RPT_MS   = 100;   // auto-repeat period
  localparam int AR_MS    = 20;    // autorange settle between steps
  localparam int BEEP_MS  = 200;   // audible indicator length
  localparam int FLASH_MS = 50;    // least visible overload flash
  localparam int TONE_HZ  = 2000;  // beep tone into headphones
  localparam int HOLD_CYC  = HOLD_MS * (CLK_HZ / 1000);
  localparam int RPT_CYC   = RPT_MS * (CLK_HZ / 1000);
  localparam int AR_CYC    = AR_MS * (CLK_HZ / 1000);
  localparam int BEEP_CYC  = BEEP_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int TONE_HALF = CLK_HZ / (2 * TONE_HZ);
  // ******************************************
  // attenuation and input
  // ******************************************
  localparam logic [2:0] ATT_MAX     = 3'h7;
  localparam logic [2:0] ATT_RST     = 3'h2;   // 20 dB at power up
  localparam logic [6:0] ATT_STEP_DB = 7'h0A;
  localparam logic       IN_RST      = 1'b0;   // 0 = input 1
  // ******************************************
  // register map
  // ******************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ATT   = 8'h04;
  localparam logic [7:0] REG_INSEL = 8'h08;
  localparam logic [7:0] REG_DC    = 8'h0C;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam int CTRL_REMOTE = 0;
  localparam int CTRL_AR     = 1;
  localparam int CTRL_MDC    = 2;
  // ******************************************
  // synchronised pin positions
  // ******************************************
  localparam int PIN_UP  = 0;
  localparam int PIN_DN  = 1;
  localparam int PIN_IN1 = 2;
  localparam int PIN_IN2 = 3;
  localparam int PIN_FEO = 4;
  localparam int PIN_FEU = 5;
  localparam int PIN_DCO = 6;
  localparam int PIN_DCU = 7;
  localparam int PIN_BEO = 8;
  localparam int PIN_UNL = 9;
  localparam int PIN_FLT = 10;
  localparam int PIN_N   = 11;
  // ******************************************
  // display characters
  // ******************************************
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_0  = 8'h30;
  localparam logic [7:0] CH_D  = 8'h64;
  localparam logic [7:0] CH_B  = 8'h42;
  localparam logic [7:0] CH_LP = 8'h28;
  localparam logic [7:0] CH_RP = 8'h29;
endpackage

// File: hw/rfap_ctrl.sv
// rf input selection and input attenuation panel controller
// What this block does
// RULE_01 - attenuation has eight settings, 0-70 dB
// RULE_02 - up arrow adds 10 dB, down removes
// RULE_03 - down at 0 dB stays, beeps
// RULE_04 - up at 70 dB stays, beeps
// RULE_05 - held arrow auto-repeats after delay
// RULE_06 - display shows value then dB
// RULE_07 - autorange ignores arrows, follows overload/underload
// RULE_08 - autorange shows parentheses, lights indicator
// RULE_09 - remote: bus sets attenuation, buttons ignored
// RULE_10 - leaving remote keeps last attenuation
// RULE_11 - downconverter: own fixed, arrows steer downconverter
// RULE_12 - downconverter autorange steers downconverter attenuation
// RULE_13 - input button selects, one led lit
// RULE_14 - remote: bus selects input, leds follow
// RULE_15 - downconverter forces input 1, buttons steer downconverter
// RULE_16 - leaving downconverter restores earlier input
// RULE_17 - leaving remote keeps remote input choice
// RULE_18 - limits, errors, faults sound piezo and tone
// RULE_19 - bandwidth flag when freq below twice bandwidth
// RULE_20 - gap flag when step exceeds bandwidth
// RULE_21 - overload flags flash short, stay sustained
// RULE_22 - unlock flag follows synthesizer lock loss
// RULE_23 - attenuation held as three-bit step index
`timescale 1ns/1ps
module rfap_ctrl #(
  parameter int unsigned      HOLD_CYC  = rfap_pkg::HOLD_CYC,
  parameter int unsigned      RPT_CYC   = rfap_pkg::RPT_CYC,
  parameter int unsigned      AR_CYC    = rfap_pkg::AR_CYC,
  parameter int unsigned      BEEP_CYC  = rfap_pkg::BEEP_CYC,
  parameter int unsigned      FLASH_CYC = rfap_pkg::FLASH_CYC,
  parameter logic      [2:0]  MDC_ATT   = 3'h0,
  parameter int               FW        = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wr_data,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [31:0]   rd_data,
  input  wire logic          btn_att_up,
  input  wire logic          btn_att_dn,
  input  wire logic          btn_in1,
  input  wire logic          btn_in2,
  input  wire logic          fe_overload,
  input  wire logic          fe_underload,
  input  wire logic          dc_overload,
  input  wire logic          dc_underload,
  input  wire logic          be_overload,
  input  wire logic          lo_unlock,
  input  wire logic          hw_fault,
  input  wire logic          tune_below_1g,
  input  wire logic [FW-1:0] tuned_freq,
  input  wire logic [FW-1:0] if_bw,
  input  wire logic [FW-1:0] tune_step,
  output logic      [2:0]    att_idx,
  output logic      [6:0]    att_db,
  output logic      [31:0]   att_disp,
  output logic               autorange_led,
  output logic               in1_led,
  output logic               in2_led,
  output logic               rf_in2_sel,
  output logic      [2:0]    dc_att_idx,
  output logic               dc_in2_sel,
  output logic               beep_piezo,
  output logic               beep_audio,
  output logic               front_end_overload_flag,
  output logic               back_end_overload_flag,
  output logic               unlock_flag,
  output logic               bandwidth_limit_flag,
  output logic               coverage_gap_flag
);

  // ****************************************
  // helpers
  // ****************************************
  // saturating step of the index
  function automatic logic [2:0] rfap_step(input logic [2:0] v, input logic up);
    if (up)
      rfap_step = (v == rfap_pkg::ATT_MAX) ? v : v + 3'h1;
    else
      rfap_step = (v == 3'h0) ? v : v - 3'h1;
  endfunction

  function automatic logic rfap_at_lim(input logic [2:0] v, input logic up);
    rfap_at_lim = up ? (v == rfap_pkg::ATT_MAX) : (v == 3'h0);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [rfap_pkg::PIN_N-1:0] s1_q, s2_q, p_q;
  wire logic [rfap_pkg::PIN_N-1:0] pins = {hw_fault, lo_unlock, be_overload,
    dc_underload, dc_overload, fe_underload, fe_overload, btn_in2, btn_in1,
    btn_att_dn, btn_att_up};

  // two flops, then a third copy for edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      p_q  <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      p_q  <= s2_q;
    end
  end

  wire logic [rfap_pkg::PIN_N-1:0] rise = s2_q & ~p_q;
  wire logic up_s = s2_q[rfap_pkg::PIN_UP];
  wire logic dn_s = s2_q[rfap_pkg::PIN_DN];

  // ****************************************
  // mode register
  // ****************************************
  logic remote_q, ar_en_q, mdc_q, mdc_d;
  wire logic wr_ctrl = wr_stb && addr == rfap_pkg::REG_CTRL;
  wire logic wr_att  = wr_stb && addr == rfap_pkg::REG_ATT;
  wire logic wr_in   = wr_stb && addr == rfap_pkg::REG_INSEL;
  wire logic ar_eff  = ar_en_q && !remote_q;  // no autorange in remote [RULE_09]

  // tuning under 1 GHz ends downconverter mode and wins over a set
  always_comb begin
    mdc_d = mdc_q;
    if (wr_ctrl)
      mdc_d = wr_data[rfap_pkg::CTRL_MDC];
    if (tune_below_1g)
      mdc_d = 1'b0;  // [RULE_16]
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      remote_q <= 1'b0;
      ar_en_q  <= 1'b0;
      mdc_q    <= 1'b0;
    end else begin
      mdc_q <= mdc_d;
      if (wr_ctrl) begin
        remote_q <= wr_data[rfap_pkg::CTRL_REMOTE];
        ar_en_q  <= wr_data[rfap_pkg::CTRL_AR];
      end
    end
  end

  // ****************************************
  // arrow auto-repeat
  // ****************************************
  logic [31:0] rpt_q;
  logic        held_p_q;
  wire logic held = up_s ^ dn_s;  // both at once means neither
  wire logic rpt_hit = rpt_q == 32'(HOLD_CYC - 1);
  wire logic step_tick = held && (!held_p_q || rpt_hit);  // [RULE_05]

  // first step on press, next after hold, then every repeat period
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rpt_q    <= '0;
      held_p_q <= 1'b0;
    end else begin
      held_p_q <= held;
      if (!held)
        rpt_q <= '0;
      else if (rpt_hit)
        rpt_q <= 32'(HOLD_CYC - RPT_CYC);  // [RULE_05]
      else
        rpt_q <= rpt_q + 32'h1;
    end
  end

  // ****************************************
  // autorange pacing
  // ****************************************
  logic [31:0] ar_q;
  wire logic ar_tick = ar_eff && ar_q == 32'(AR_CYC - 1);

  // settle time so one overload does not run the attenuator to the end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      ar_q <= '0;
    else if (!ar_eff || ar_tick)
      ar_q <= '0;
    else
      ar_q <= ar_q + 32'h1;
  end

  // ****************************************
  // attenuation
  // ****************************************
  logic [2:0] att_q, dc_att_q;
  wire logic  man_ok  = step_tick && !remote_q && !ar_eff;  // [RULE_07]
  wire logic  att_bad = wr_att && remote_q && wr_data[3];
  wire logic  lim_hit = man_ok && rfap_at_lim(mdc_q ? dc_att_q : att_q, up_s);

  // own setting; frozen in downconverter mode except for bus writes in remote
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      att_q <= rfap_pkg::ATT_RST;
    else if (remote_q) begin
      if (wr_att && !wr_data[3])
        att_q <= wr_data[2:0];  // [RULE_09] [RULE_23]
    end else if (!mdc_q) begin
      if (ar_tick && s2_q[rfap_pkg::PIN_FEO])
        att_q <= rfap_step(att_q, 1'b1);  // [RULE_07]
      else if (ar_tick && s2_q[rfap_pkg::PIN_FEU])
        att_q <= rfap_step(att_q, 1'b0);  // [RULE_07]
      else if (man_ok)
        att_q <= rfap_step(att_q, up_s);  // [RULE_02] [RULE_03] [RULE_04] [RULE_10]
    end
  end

  // downconverter setting, steered only in downconverter mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      dc_att_q <= rfap_pkg::ATT_RST;
    else if (mdc_q && !remote_q) begin
      if (ar_tick && s2_q[rfap_pkg::PIN_DCO])
        dc_att_q <= rfap_step(dc_att_q, 1'b1);  // [RULE_12]
      else if (ar_tick && s2_q[rfap_pkg::PIN_DCU])
        dc_att_q <= rfap_step(dc_att_q, 1'b0);  // [RULE_12]
      else if (man_ok)
        dc_att_q <= rfap_step(dc_att_q, up_s);  // [RULE_11]
    end
  end

  wire logic [2:0] att_eff = mdc_q ? MDC_ATT : att_q;  // [RULE_11]

  // ****************************************
  // input selection
  // ****************************************
  logic in_q, saved_q, dc_in_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_q    <= rfap_pkg::IN_RST;
      saved_q <= rfap_pkg::IN_RST;
    end else begin
      if (!mdc_q && mdc_d)
        saved_q <= in_q;
      if (mdc_q && !mdc_d)
        in_q <= saved_q;  // [RULE_16]
      else if (remote_q) begin
        if (wr_in)
          in_q <= wr_data[0];  // [RULE_14] [RULE_17]
      end else if (!mdc_q) begin
        if (rise[rfap_pkg::PIN_IN1])
          in_q <= 1'b0;  // [RULE_13]
        else if (rise[rfap_pkg::PIN_IN2])
          in_q <= 1'b1;  // [RULE_13]
      end
    end
  end

  // buttons pick the downconverter input instead
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      dc_in_q <= 1'b0;
    else if (mdc_q && !remote_q) begin
      if (rise[rfap_pkg::PIN_IN1])
        dc_in_q <= 1'b0;  // [RULE_15]
      else if (rise[rfap_pkg::PIN_IN2])
        dc_in_q <= 1'b1;  // [RULE_15]
    end
  end

  // ****************************************
  // audible indicator
  // ****************************************
  logic [31:0] beep_q;
  logic [15:0] tone_q;
  logic        tone_lvl_q;
  wire logic beep_req = lim_hit || att_bad || rise[rfap_pkg::PIN_FLT];  // [RULE_18]

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      beep_q <= '0;
    else if (beep_req)
      beep_q <= 32'(BEEP_CYC);  // [RULE_03] [RULE_04] [RULE_18]
    else if (beep_q != 32'h0)
      beep_q <= beep_q - 32'h1;
  end

  // square tone for the headphone path
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tone_q     <= '0;
      tone_lvl_q <= 1'b0;
    end else if (tone_q == 16'(rfap_pkg::TONE_HALF - 1)) begin
      tone_q     <= '0;
      tone_lvl_q <= !tone_lvl_q;
    end else
      tone_q <= tone_q + 16'h1;
  end

  // ****************************************
  // status indicators
  // ****************************************
  logic [31:0] fe_str_q, be_str_q;

  // stretch so a one-cycle overload is still seen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fe_str_q <= '0;
      be_str_q <= '0;
    end else begin
      if (s2_q[rfap_pkg::PIN_FEO])
        fe_str_q <= 32'(FLASH_CYC);  // [RULE_21]
      else if (fe_str_q != 32'h0)
        fe_str_q <= fe_str_q - 32'h1;
      if (s2_q[rfap_pkg::PIN_BEO])
        be_str_q <= 32'(FLASH_CYC);  // [RULE_21]
      else if (be_str_q != 32'h0)
        be_str_q <= be_str_q - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      front_end_overload_flag <= 1'b0;
      back_end_overload_flag  <= 1'b0;
      unlock_flag             <= 1'b0;
      bandwidth_limit_flag    <= 1'b0;
      coverage_gap_flag       <= 1'b0;
    end else begin
      front_end_overload_flag <= s2_q[rfap_pkg::PIN_FEO] || fe_str_q != 32'h0;  // [RULE_21]
      back_end_overload_flag  <= s2_q[rfap_pkg::PIN_BEO] || be_str_q != 32'h0;  // [RULE_21]
      unlock_flag             <= s2_q[rfap_pkg::PIN_UNL];  // [RULE_22]
      bandwidth_limit_flag    <= {1'b0, tuned_freq} < {if_bw, 1'b0};  // [RULE_19]
      coverage_gap_flag       <= tune_step > if_bw;  // [RULE_20]
    end
  end

  // ****************************************
  // outputs and display
  // ****************************************
  logic [7:0] tens;
  always_comb begin
    tens = (att_eff == 3'h0) ? rfap_pkg::CH_SP : rfap_pkg::CH_0 + {5'h0, att_eff};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      att_idx       <= rfap_pkg::ATT_RST;
      att_db        <= '0;
      att_disp      <= {4{rfap_pkg::CH_SP}};
      autorange_led <= 1'b0;
      in1_led       <= 1'b1;
      in2_led       <= 1'b0;
      rf_in2_sel    <= 1'b0;
      dc_att_idx    <= rfap_pkg::ATT_RST;
      dc_in2_sel    <= 1'b0;
      beep_piezo    <= 1'b0;
      beep_audio    <= 1'b0;
    end else begin
      att_idx       <= att_eff;  // [RULE_01] [RULE_23]
      att_db        <= 7'(att_eff * rfap_pkg::ATT_STEP_DB);  // [RULE_23]
      if (ar_eff)
        att_disp <= {rfap_pkg::CH_LP, tens, rfap_pkg::CH_0, rfap_pkg::CH_RP};  // [RULE_08]
      else
        att_disp <= {tens, rfap_pkg::CH_0, rfap_pkg::CH_D, rfap_pkg::CH_B};  // [RULE_06]
      autorange_led <= ar_eff;  // [RULE_08]
      in1_led       <= !(in_q && !mdc_q);  // [RULE_13] [RULE_14]
      in2_led       <= in_q && !mdc_q;
      rf_in2_sel    <= in_q && !mdc_q;  // [RULE_15]
      dc_att_idx    <= dc_att_q;
      dc_in2_sel    <= dc_in_q;
      beep_piezo    <= beep_q != 32'h0;  // [RULE_18]
      beep_audio    <= beep_q != 32'h0 && tone_lvl_q;  // [RULE_18]
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      rd_data <= '0;
    else if (rd_stb) begin
      unique case (addr)
        rfap_pkg::REG_CTRL:  rd_data <= {29'h0, mdc_q, ar_en_q, remote_q};
        rfap_pkg::REG_ATT:   rd_data <= {29'h0, att_q};
        rfap_pkg::REG_INSEL: rd_data <= {31'h0, in_q};
        rfap_pkg::REG_DC:    rd_data <= {28'h0, dc_in_q, dc_att_q};
        rfap_pkg::REG_STAT:  rd_data <= {25'h0, beep_piezo, ar_eff, unlock_flag,
          coverage_gap_flag, bandwidth_limit_flag, back_end_overload_flag,
          front_end_overload_flag};
        default:             rd_data <= '0;
      endcase
    end else
      rd_data <= '0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence mdc_exit_s;
    mdc_q ##1 !mdc_q;
  endsequence

  att_up_step_a: assert property (man_ok && !mdc_q && up_s && att_q != 3'h7 && !ar_tick  // [RULE_02]
    |=> att_q == $past(att_q) + 3'h1) else $error("up step not applied");
  att_floor_a: assert property (man_ok && !mdc_q && dn_s && att_q == 3'h0  // [RULE_03]
    |=> att_q == 3'h0 ##1 beep_piezo) else $error("floor not held or no beep");
  att_ceil_a: assert property (man_ok && !mdc_q && up_s && att_q == 3'h7  // [RULE_04]
    |=> att_q == 3'h7 ##1 beep_piezo) else $error("ceiling not held or no beep");
  ar_ignore_a: assert property (ar_eff && !ar_tick && !wr_ctrl  // [RULE_07]
    |=> $stable(att_q) && $stable(dc_att_q)) else $error("arrows moved autorange");
  remote_hold_a: assert property (remote_q && !wr_att |=> $stable(att_q))  // [RULE_09]
    else $error("attenuation moved in remote");
  led_onehot_a: assert property (in1_led != in2_led)  // [RULE_13]
    else $error("input leds not one-hot");
  mdc_force_a: assert property (mdc_q |=> !rf_in2_sel && att_idx == MDC_ATT)  // [RULE_15]
    else $error("downconverter mode not forcing input and attenuation");
  mdc_restore_a: assert property (mdc_exit_s |-> in_q == $past(saved_q))  // [RULE_16]
    else $error("input not restored");
  bw_limit_a: assert property (##1 bandwidth_limit_flag ==  // [RULE_19]
    ({1'b0, $past(tuned_freq)} < {$past(if_bw), 1'b0})) else $error("bandwidth flag wrong");
  beep_start_a: assert property (beep_req |=> ##1 beep_piezo [*3])  // [RULE_18]
    else $error("beep not sounded");
  disp_val_a: assert property (!ar_eff |=> att_disp[15:0] == {rfap_pkg::CH_D, rfap_pkg::CH_B})  // [RULE_06]
    else $error("display unit missing");

endmodule

// File: bench/rfap_panel.sv
// behavioural front panel and field status model for the rf panel controller
`timescale 1ns/1ps
module rfap_panel (
  input  wire logic sys_clk,
  output logic      btn_att_up,
  output logic      btn_att_dn,
  output logic      btn_in1,
  output logic      btn_in2,
  output logic      fe_overload,
  output logic      fe_underload,
  output logic      dc_overload,
  output logic      dc_underload,
  output logic      be_overload,
  output logic      lo_unlock,
  output logic      hw_fault
);
  logic [10:0] pins_q;
  // ******************************************
  // pin map
  // ******************************************
  // order follows the controller's synchroniser positions
  assign {hw_fault, lo_unlock, be_overload, dc_underload, dc_overload, fe_underload,
          fe_overload, btn_in2, btn_in1, btn_att_dn, btn_att_up} = pins_q;
  initial begin
    pins_q = 11'h000;
  end
  // levels change only just after a clock edge, as a real panel seen through sync would
  task automatic level(input int pin, input logic v);
    @(posedge sys_clk);
    pins_q[pin] <= v;
  endtask
  // a press longer than the repeat delay turns into auto-stepping
  task automatic hold(input int pin, input int n);
    level(pin, 1'b1);
    repeat (n) @(posedge sys_clk);
    pins_q[pin] <= 1'b0;
  endtask
endmodule

// File: bench/test_rfap_ctrl.sv
// self-checking testbench for the rf panel controller
`timescale 1ns/1ps
module test_rfap_ctrl;
  logic        sys_clk, rst_b, wr_stb, rd_stb, tune_below_1g;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, tuned_freq, if_bw, tune_step, att_disp;
  logic [2:0]  att_idx, dc_att_idx;
  logic [6:0]  att_db;
  logic        up, dn, in1, in2, feo, feu, dco, dcu, beo, unl, flt;
  logic        ar_led, in1_led, in2_led, in2_sel, dc_in2, beep_p, beep_a;
  logic        fe_flag, be_flag, unl_flag, bw_flag, gap_flag;
  int          fails, samples_checked, beeps, b0, tones, cyc;
  // ******************************************
  // design and panel
  // ******************************************
  rfap_ctrl #(.HOLD_CYC(20), .RPT_CYC(8), .AR_CYC(5), .BEEP_CYC(10), .FLASH_CYC(6)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .btn_att_up(up), .btn_att_dn(dn), .btn_in1(in1),
    .btn_in2(in2), .fe_overload(feo), .fe_underload(feu), .dc_overload(dco),
    .dc_underload(dcu), .be_overload(beo), .lo_unlock(unl), .hw_fault(flt),
    .tune_below_1g(tune_below_1g), .tuned_freq(tuned_freq), .if_bw(if_bw),
    .tune_step(tune_step), .att_idx(att_idx), .att_db(att_db), .att_disp(att_disp),
    .autorange_led(ar_led), .in1_led(in1_led), .in2_led(in2_led), .rf_in2_sel(in2_sel),
    .dc_att_idx(dc_att_idx), .dc_in2_sel(dc_in2), .beep_piezo(beep_p), .beep_audio(beep_a),
    .front_end_overload_flag(fe_flag), .back_end_overload_flag(be_flag),
    .unlock_flag(unl_flag), .bandwidth_limit_flag(bw_flag), .coverage_gap_flag(gap_flag));
  rfap_panel u_panel (
    .sys_clk(sys_clk), .btn_att_up(up), .btn_att_dn(dn), .btn_in1(in1), .btn_in2(in2),
    .fe_overload(feo), .fe_underload(feu), .dc_overload(dco), .dc_underload(dcu),
    .be_overload(beo), .lo_unlock(unl), .hw_fault(flt));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // beep cycles are counted so short beeps are never missed between checks
  always @(posedge sys_clk) begin
    if (beep_p === 1'b1) beeps <= beeps + 1;
    if (beep_a === 1'b1) tones <= tones + 1;
    if (rst_b === 1'b1) cyc <= cyc + 1;
  end
  // ******************************************
  // helpers
  // ******************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
    chk(rd_data, exp);
  endtask
  function automatic logic [31:0] disp(input logic [2:0] i, input logic ar);
    logic [7:0] d;
    d = (i == 3'h0) ? rfap_pkg::CH_SP : rfap_pkg::CH_0 + {5'h00, i};
    disp = ar ? {rfap_pkg::CH_LP, d, rfap_pkg::CH_0, rfap_pkg::CH_RP}
              : {d, rfap_pkg::CH_0, rfap_pkg::CH_D, rfap_pkg::CH_B};
  endfunction
  task automatic att(input logic [2:0] i, input logic ar);
    chk({29'h0, att_idx}, {29'h0, i});
    chk({25'h0, att_db}, {29'h0, i} * 32'h0000000A);
    chk(att_disp, disp(i, ar));
  endtask
  task automatic press(input int pin, input int n);
    u_panel.hold(pin, n);
    tick(6);
  endtask
  task automatic end_of_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the sequence needs about 4000 cycles
  initial begin
    tick(20000);
    fails++;
    end_of_test();
  end
  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    rst_b = 1'b0; addr = 8'h00; wr_data = 32'h0; wr_stb = 1'b0; rd_stb = 1'b0;
    tune_below_1g = 1'b0; tuned_freq = 32'h64; if_bw = 32'h10; tune_step = 32'h1;
    fails = 0; samples_checked = 0; beeps = 0; tones = 0; cyc = 0;
    tick(20);
    rst_b <= 1'b1;
    tick(3);
    att(3'h2, 1'b0);
    chk({in2_sel, in2_led, in1_led}, 32'h1);
    press(rfap_pkg::PIN_UP, 3);
    att(3'h3, 1'b0);
    repeat (3) press(rfap_pkg::PIN_DN, 3);
    att(3'h0, 1'b0);
    b0 = beeps;
    press(rfap_pkg::PIN_DN, 3);
    att(3'h0, 1'b0);
    chk(beeps > b0, 32'h1);
    // held arrow: one step, a pause, then repeats up to the top and a beep
    u_panel.level(rfap_pkg::PIN_UP, 1'b1);
    tick(18);
    att(3'h1, 1'b0);
    b0 = beeps;
    tick(82);
    att(3'h7, 1'b0);
    chk(beeps > b0, 32'h1);
    u_panel.level(rfap_pkg::PIN_UP, 1'b0);
    press(rfap_pkg::PIN_IN2, 3);
    chk({in2_sel, in2_led, in1_led}, 32'h6);
    // remote: panel ignored, bus rules
    wr(rfap_pkg::REG_CTRL, 32'h1);
    rd(rfap_pkg::REG_CTRL, 32'h1);
    press(rfap_pkg::PIN_DN, 3);
    att(3'h7, 1'b0);
    wr(rfap_pkg::REG_ATT, 32'h5);
    tick(4);
    att(3'h5, 1'b0);
    rd(rfap_pkg::REG_ATT, 32'h5);
    b0 = beeps;
    wr(rfap_pkg::REG_ATT, 32'hB);
    tick(6);
    att(3'h5, 1'b0);
    chk(beeps > b0, 32'h1);
    press(rfap_pkg::PIN_IN1, 3);
    chk({in2_sel, in2_led, in1_led}, 32'h6);
    wr(rfap_pkg::REG_INSEL, 32'h0);
    tick(4);
    chk({in2_sel, in2_led, in1_led}, 32'h1);
    rd(8'h40, 32'h0);
    wr(rfap_pkg::REG_CTRL, 32'h0);
    tick(4);
    att(3'h5, 1'b0);
    chk({in2_sel, in2_led, in1_led}, 32'h1);
    press(rfap_pkg::PIN_DN, 3);
    att(3'h4, 1'b0);
    // autorange: arrows ignored, overload steps up, underload down
    wr(rfap_pkg::REG_CTRL, 32'h2);
    tick(4);
    att(3'h4, 1'b1);
    chk(ar_led, 32'h1);
    press(rfap_pkg::PIN_DN, 3);
    att(3'h4, 1'b1);
    u_panel.level(rfap_pkg::PIN_FEO, 1'b1);
    tick(4);
    chk(fe_flag, 32'h1);
    tick(8);
    chk(att_idx > 3'h4, 32'h1);
    u_panel.level(rfap_pkg::PIN_FEO, 1'b0);
    tick(20);
    chk(fe_flag, 32'h0);
    wr(rfap_pkg::REG_CTRL, 32'h3);
    tick(3);
    chk(ar_led, 32'h0);
    wr(rfap_pkg::REG_CTRL, 32'h2);
    u_panel.level(rfap_pkg::PIN_FEU, 1'b1);
    tick(60);
    att(3'h0, 1'b1);
    u_panel.level(rfap_pkg::PIN_FEU, 1'b0);
    // downconverter mode and its exit
    wr(rfap_pkg::REG_CTRL, 32'h0);
    press(rfap_pkg::PIN_UP, 3);
    press(rfap_pkg::PIN_IN2, 3);
    wr(rfap_pkg::REG_CTRL, 32'h4);
    tick(4);
    chk({in2_sel, in1_led, 1'b0, att_idx}, 32'h10);
    press(rfap_pkg::PIN_UP, 3);
    press(rfap_pkg::PIN_IN2, 3);
    chk({dc_in2, in2_sel, 1'b0, dc_att_idx, 1'b0, att_idx}, 32'h230);
    wr(rfap_pkg::REG_CTRL, 32'h6);
    u_panel.level(rfap_pkg::PIN_DCO, 1'b1);
    tick(12);
    chk({dc_att_idx > 3'h3, 1'b0, att_idx}, 32'h10);
    u_panel.level(rfap_pkg::PIN_DCO, 1'b0);
    tune_below_1g <= 1'b1;
    tick(4);
    chk({in2_sel, in2_led, in1_led}, 32'h6);
    att(3'h1, 1'b1);
    // status flags
    tuned_freq <= 32'd100; if_bw <= 32'd60; tune_step <= 32'd60;
    tick(3);
    chk({bw_flag, gap_flag}, 32'h2);
    tuned_freq <= 32'd120; tune_step <= 32'd61;
    tick(3);
    chk({bw_flag, gap_flag}, 32'h1);
    u_panel.level(rfap_pkg::PIN_BEO, 1'b1);
    u_panel.level(rfap_pkg::PIN_UNL, 1'b1);
    tick(4);
    chk({be_flag, unl_flag}, 32'h3);
    u_panel.level(rfap_pkg::PIN_BEO, 1'b0);
    u_panel.level(rfap_pkg::PIN_UNL, 1'b0);
    tick(20);
    chk({be_flag, unl_flag}, 32'h0);
    // tone sits low for its first half period, so no beep has reached the headphones
    chk(tones, 32'h0);
    while (cyc < rfap_pkg::TONE_HALF * 3 / 2) tick(1);
    b0 = beeps;
    press(rfap_pkg::PIN_FLT, 3);
    chk(beeps > b0, 32'h1);
    chk(tones > 0, 32'h1);
    end_of_test();
  end
endmodule
